// [core/deep_sleep_gating_and_soft_reset.sv]
// Function
// - set gating bit clocks its port
// - access to gated port faults
// - gating bits reset to zero
// - separate run, sleep, deep-sleep registers
// - low-power registers apply only with auto-gate
// - deep-sleep bits 4:0 enable ports E..A
// - unimplemented bits read zero
// - soft reset writes masked by capabilities
// - bit 20 resets pwm unit
// - bit 16 resets converter zero
// - bit 3 resets watchdog, rest zero
// - soft reset register at 0x040, zero reset
// - deep-sleep register at 0x128, zero reset
// - run register, same layout, while running
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
module deep_sleep_gating_and_soft_reset
  import sysctl_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [11:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] capability_mask_one_in,
  input wire logic [1:0] power_state_in,
  input wire logic [4:0] port_access_in,
  output logic [31:0] rdata_out,
  output logic [4:0] port_clk_en_out,
  output logic [4:0] port_fault_out,
  output logic pwm_rst_out,
  output logic adc_rst_out,
  output logic wdt_rst_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sysctl_state_s cur;
  sysctl_state_s nxt;
  reg_req_s req;
  power_state_e pstate;
  logic [4:0] active_gate;

  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
  assign pstate = power_state_e'(power_state_in);

  // ----------------------------------------------------------------
  // gating selection
  // ----------------------------------------------------------------
  // without auto-gate, low-power states keep the run enables
  always_comb begin
    case (pstate)
      pwr_run: active_gate = cur.run_gate;
      pwr_sleep: active_gate = cur.auto_gate ? cur.sleep_gate : cur.run_gate;
      pwr_deep: active_gate = cur.auto_gate ? cur.deep_gate : cur.run_gate;
      default: active_gate = cur.run_gate;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt = cur;
    nxt.rdata = 32'h00000000;
    if (req.wr) begin
      case (req.addr)
        run_gating_off: nxt.run_gate = req.wdata[4:0] & gating_mask;
        sleep_gating_off: nxt.sleep_gate = req.wdata[4:0] & gating_mask;
        deep_sleep_gating_off: nxt.deep_gate = req.wdata[4:0] & gating_mask;
        // writes only land on bits that exist and are present
        soft_reset_ctrl_zero_off: nxt.soft_reset = req.wdata & soft_reset_writable
                                                   & capability_mask_one_in;
        power_ctrl_off: nxt.auto_gate = req.wdata[auto_clock_gate_select];
        default: ;
      endcase
    end
    if (req.rd) begin
      case (req.addr)
        run_gating_off: nxt.rdata = {27'h0000000, cur.run_gate};
        sleep_gating_off: nxt.rdata = {27'h0000000, cur.sleep_gate};
        deep_sleep_gating_off: nxt.rdata = {27'h0000000, cur.deep_gate};
        soft_reset_ctrl_zero_off: nxt.rdata = cur.soft_reset;
        power_ctrl_off: nxt.rdata = {29'h00000000, power_state_in, cur.auto_gate};
        fault_status_off: nxt.rdata = {27'h0000000, cur.fault_sticky};
        default: nxt.rdata = 32'h00000000;
      endcase
    end
    nxt.port_clk_en = active_gate;
    nxt.port_fault = port_access_in & ~active_gate;
    // a new fault wins over the clear in the same cycle
    if (req.wr && req.addr == fault_status_off) begin
      nxt.fault_sticky = cur.fault_sticky & ~req.wdata[4:0];
    end
    nxt.fault_sticky = nxt.fault_sticky | (port_access_in & ~active_gate);
    nxt.pwm_rst = cur.soft_reset[pwm_reset_pos];
    nxt.adc_rst = cur.soft_reset[adc_reset_pos];
    nxt.wdt_rst = cur.soft_reset[watchdog_reset_bit];
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cur <= '0;
    end else begin
      cur <= nxt;
    end
  end

  assign rdata_out = cur.rdata;
  assign port_clk_en_out = cur.port_clk_en;
  assign port_fault_out = cur.port_fault;
  assign pwm_rst_out = cur.pwm_rst;
  assign adc_rst_out = cur.adc_rst;
  assign wdt_rst_out = cur.wdt_rst;

endmodule

// [core/sysctl_pkg.sv]
package sysctl_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] soft_reset_ctrl_zero_off = 12'h040;
  localparam logic [11:0] run_gating_off = 12'h100;
  localparam logic [11:0] sleep_gating_off = 12'h118;
  localparam logic [11:0] deep_sleep_gating_off = 12'h128;
  localparam logic [11:0] power_ctrl_off = 12'h200;
  localparam logic [11:0] fault_status_off = 12'h204;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int port_count = 5;
  localparam logic [4:0] gating_mask = 5'h1f;
  localparam logic [31:0] gating_reset = 32'h00000000;
  localparam int pwm_reset_pos = 20;
  localparam int adc_reset_pos = 16;
  localparam int watchdog_reset_bit = 3;
  localparam logic [31:0] soft_reset_writable = 32'h00110008;
  localparam logic [31:0] soft_reset_reset = 32'h00000000;
  localparam int auto_clock_gate_select = 0;
  localparam int power_state_lsb = 1;

  typedef enum logic [1:0] {
    pwr_run = 2'b00,
    pwr_sleep = 2'b01,
    pwr_deep = 2'b10
  } power_state_e;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    logic [4:0] run_gate;
    logic [4:0] sleep_gate;
    logic [4:0] deep_gate;
    logic [31:0] soft_reset;
    logic auto_gate;
    logic [31:0] rdata;
    logic [4:0] port_clk_en;
    logic [4:0] port_fault;
    logic [4:0] fault_sticky;
    logic pwm_rst;
    logic adc_rst;
    logic wdt_rst;
  } sysctl_state_s;

endpackage

// [sim/port_access_model.sv]
`timescale 1ns/1ps
module port_access_model (
  input logic clk_in,
  input logic [4:0] req_in,
  output logic [4:0] access_out = 5'h00
);
  always @(posedge clk_in) access_out <= req_in;
endmodule

// [sim/sysctl_checker.sv]
`timescale 1ns/1ps
module sysctl_checker (
  input logic mclk_in, rst_n_in, wr_in, rd_in, pwm_rst_out, adc_rst_out, wdt_rst_out,
  input logic [11:0] addr_in,
  input logic [31:0] wdata_in, capability_mask_one_in, rdata_out,
  input logic [1:0] power_state_in,
  input logic [4:0] port_access_in, port_clk_en_out, port_fault_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // output lags the taking edge by two samples
  sequence s_wr(b); wr_in && addr_in == 12'h040 && wdata_in[b] && capability_mask_one_in[b]; endsequence
  property p_rd; rdata_out != 0 |-> $past(rd_in); endproperty
  a_rd: assert property (p_rd) else $error("stray rdata");
  property p_dg; $past(rd_in && addr_in == 12'h128) |-> rdata_out[31:5] == 0; endproperty
  a_dg: assert property (p_dg) else $error("gate rsvd");
  property p_sr; $past(rd_in && addr_in == 12'h040) |-> (rdata_out & 32'hffeefff7) == 0; endproperty
  a_sr: assert property (p_sr) else $error("reset rsvd");
  property p_ft; (port_fault_out & ~$past(port_access_in)) == 5'h00; endproperty
  a_ft: assert property (p_ft) else $error("stray fault");
  property p_wd; s_wr(3) |-> ##2 wdt_rst_out; endproperty
  a_wd: assert property (p_wd) else $error("wdt reset");
  property p_pw; s_wr(20) |-> ##2 pwm_rst_out; endproperty
  a_pw: assert property (p_pw) else $error("pwm reset");
  property p_mk; $rose(adc_rst_out) |-> $past(capability_mask_one_in[16], 2); endproperty
  a_mk: assert property (p_mk) else $error("unmasked");
  property p_hd; !(wr_in || $changed(power_state_in)) [*3] |=> $stable(port_clk_en_out); endproperty
  a_hd: assert property (p_hd) else $error("gate moved");
endmodule
bind deep_sleep_gating_and_soft_reset sysctl_checker sysctl_checker_inst (.*);

// [sim/tb.sv]
`timescale 1ns/1ps
module tb;
  logic mclk_in = 0, rst_n = 0, wr = 0, rd = 0, pwm, adc, wdt;
  logic [11:0] addr = 0;
  logic [31:0] wdata = 0, cap = 0, rdata;
  logic [1:0] pw = 0;
  logic [4:0] req = 0, acc, en, flt;
  int miscompares = 0, total_checks = 0;
  always #2.5 mclk_in = ~mclk_in;
  port_access_model port_access_model_inst (.clk_in(mclk_in), .req_in(req), .access_out(acc));
  deep_sleep_gating_and_soft_reset deep_sleep_gating_and_soft_reset_inst (.mclk_in(mclk_in), .rst_n_in(rst_n),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .capability_mask_one_in(cap), .power_state_in(pw),
    .port_access_in(acc), .rdata_out(rdata), .port_clk_en_out(en), .port_fault_out(flt), .pwm_rst_out(pwm),
    .adc_rst_out(adc), .wdt_rst_out(wdt));
  task chk(input logic [31:0] g, e);
    total_checks++;
    miscompares += int'(g !== e);
    if (g !== e) $display("ERROR %0t got %h want %h", $time, g, e);
  endtask
  // reads compare against d, writes send it
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr <= a;
    wdata <= d;
    {wr, rd} <= {w, !w};
    @(posedge mclk_in);
    {wr, rd} <= 2'b00;
    #1 if (!w) chk(rdata, d);
  endtask
  // fault shows two edges after the request
  task step(input logic [1:0] p, input logic [4:0] m);
    @(posedge mclk_in);
    pw <= p;
    req <= m;
    @(posedge mclk_in);
    req <= 5'h00;
    @(posedge mclk_in) #1;
  endtask
  task end_of_test;
    if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #5000;
    miscompares++;
    end_of_test;
  end
  initial begin
    repeat (5) @(posedge mclk_in);
    rst_n <= 1;
    bus(0, 12'h040, 0);
    bus(0, 12'h128, 0);
    chk(en, 0);
    bus(1, 12'h128, 32'hffffffff);
    bus(0, 12'h128, 32'h1f);
    bus(0, 12'h3fc, 0);
    bus(1, 12'h100, 32'h25);
    step(0, 5'h1f);
    chk({en, flt}, 10'h0ba);
    step(2, 5'h05);
    chk({en, flt}, 10'h0a0);
    bus(1, 12'h200, 1);
    step(2, 5'h1f);
    chk({en, flt}, 10'h3e0);
    step(1, 5'h01);
    chk({en, flt}, 10'h001);
    bus(0, 12'h200, 32'h3);
    bus(0, 12'h204, 32'h1b);
    bus(1, 12'h204, 32'h1f);
    bus(0, 12'h204, 32'h0);
    bus(1, 12'h118, 32'hffffffff);
    bus(0, 12'h118, 32'h1f);
    @(posedge mclk_in) cap <= 32'hffffffff;
    bus(1, 12'h040, 32'hffffffff);
    @(posedge mclk_in) #1 chk({pwm, adc, wdt}, 3'h7);
    bus(0, 12'h040, 32'h00110008);
    @(posedge mclk_in) cap <= 32'h00000008;
    bus(1, 12'h040, 32'hffffffff);
    bus(0, 12'h040, 32'h8);
    chk({pwm, adc, wdt}, 3'h1);
    end_of_test;
  end
endmodule
